//--- hw/cpu_clk_regs.svh
`ifndef CPU_CLK_REGS_SVH
`define CPU_CLK_REGS_SVH

// register indexes; byte address is four times the index, low 10 bits decoded
`define IDX_POWER_SAVE_CONTROL      32'h0FFF_F1FE
`define IDX_PROCESSOR_CLOCK_CONTROL 32'hFFFF_F828
`define IDX_POWER_SAVE_MODE         32'h0000_002A
`define IDX_PROTECT_COMMAND         32'h0000_00FC
`define IDX_OSC_SETTLE_SELECT       32'h0000_002B

// processor_clock_control fields
`define PCC_SUB_FEEDBACK_OFF 7
`define PCC_MAIN_OSC_STOP    6
`define PCC_MAIN_FEEDBACK_OFF 5
`define PCC_CPU_ON_SUBCLOCK  4
`define PCC_CLK_SEL_TOP      3
`define PCC_RESET            8'h03

// power_save_control fields
`define PSC_WDT_NMI_MASK      7
`define PSC_PIN_NMI_MASK      5
`define PSC_MASKABLE_IRQ_MASK 4
`define PSC_STANDBY_REQUEST   1
`define PSC_RESET             8'h00
`define PSC_WRITABLE          8'hB2

// power_save_mode fields
`define POWER_SAVE_MODE_STANDBY_KIND_SELECT 0
`define POWER_SAVE_MODE_RESET               8'h00

// osc_settle_select reset; protect command key
`define OSC_SETTLE_SELECT_RESET   8'h04
`define PROTECT_KEY  8'hA5

`endif

//--- hw/cpu_clk_pkg.sv
package cpu_clk_pkg;
  typedef enum logic {
    STANDBY_IDLE,
    STANDBY_STOP
  } standby_kind_t;

  typedef logic [7:0] reg8_t;

  typedef enum {
    SW_MAIN,
    SW_TO_SUB,
    SW_SUB,
    SW_TO_MAIN
  } switch_state_t;
endpackage : cpu_clk_pkg

//--- hw/clk_switch_if.sv
`timescale 1ns/1ns
interface clk_switch_if;
  logic want_sub;
  logic main_en;
  logic sub_tick;
  logic on_sub;
  logic cpu_en;

  modport ctrl (
    output want_sub,
    output main_en,
    output sub_tick,
    input  on_sub,
    input  cpu_en
  );
  modport sw (
    input  want_sub,
    input  main_en,
    input  sub_tick,
    output on_sub,
    output cpu_en
  );
endinterface : clk_switch_if

//--- hw/clk_switch.sv
`timescale 1ns/1ns
module clk_switch (
  input wire logic   clk,
  input wire logic   resetn,
  clk_switch_if.sw   sw
);
  import cpu_clk_pkg::*;

  switch_state_t state;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= SW_MAIN;
    end else begin
      unique case (state)
        SW_MAIN: begin
          if (sw.want_sub && sw.main_en) begin
            state <= SW_TO_SUB;
          end
        end
        SW_TO_SUB: begin
          if (sw.sub_tick) begin
            state <= SW_SUB;
          end
        end
        SW_SUB: begin
          if (!sw.want_sub && sw.sub_tick) begin
            state <= SW_TO_MAIN;
          end
        end
        SW_TO_MAIN: begin
          if (sw.main_en) begin
            state <= SW_MAIN;
          end
        end
      endcase
    end
  end

  assign sw.on_sub = (state == SW_SUB) || (state == SW_TO_MAIN);

  // no enable pulses leak out while in transit
  assign sw.cpu_en = (state == SW_MAIN) ? sw.main_en :
                     (state == SW_SUB)  ? sw.sub_tick : 1'b0;
endmodule : clk_switch

//--- hw/cpu_clock_and_standby_control.sv
// Operation
// - clock control writes need unlock sequence
// - power save control writes need unlock
// - byte and single-bit access, all three
// - clock control resets to 03H
// - bit 7 cuts subclock feedback resistor
// - main stop only after subclock switch
// - bit 5 cuts main feedback resistor
// - bit 4 read-only subclock status
// - selector picks divider or subclock
// - wait access stalls without main clock
// - switch completes later, poll status
// - power save control layout, resets 00H
// - masks act only in STOP
// - standby request enters standby
// - power save mode resets 00H
// - kind select matters only on request
// - settle delay after reset and STOP
// - main oscillator stops in STOP
`timescale 1ns/1ns
`include "cpu_clk_regs.svh"
module cpu_clock_and_standby_control #(
  parameter int ADDR_W       = 12,
  parameter int SETTLE_SHIFT = 8
) (
  input  wire logic               CLK,
  input  wire logic               RESETN,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]        PWDATA,
  input  wire logic [3:0]         PSTRB,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               SUB_OSC_IN,
  input  wire logic               MAIN_OSC_INPUT_ALIVE,
  input  wire logic               WATCHDOG_NMI_REQUEST,
  input  wire logic               PIN_NMI_REQUEST,
  input  wire logic               MASKABLE_IRQ_REQUEST,
  output logic                    CPU_CLK_EN,
  output logic                    SYS_CLK_EN,
  output logic                    MAIN_OSC_STOP,
  output logic                    MAIN_FEEDBACK_OFF,
  output logic                    SUB_FEEDBACK_OFF,
  output logic                    IN_IDLE,
  output logic                    IN_STOP,
  output logic                    SETTLING,
  output logic                    WAKE_EVENT
);
  import cpu_clk_pkg::*;

  localparam logic [9:0] A_PSC  = 10'(`IDX_POWER_SAVE_CONTROL);
  localparam logic [9:0] A_PCC  = 10'(`IDX_PROCESSOR_CLOCK_CONTROL);
  localparam logic [9:0] A_POWER_SAVE_MODE = 10'(`IDX_POWER_SAVE_MODE);
  localparam logic [9:0] A_PROT = 10'(`IDX_PROTECT_COMMAND);
  localparam logic [9:0] A_OSC_SETTLE_SELECT = 10'(`IDX_OSC_SETTLE_SELECT);

  reg8_t processor_clock_control;
  reg8_t power_save_control;
  reg8_t power_save_mode;
  reg8_t osc_settle_select;
  logic  protect_armed;

  logic [4:0]  div_cnt;
  logic        main_en;
  logic [2:0]  sub_sync;
  logic        sub_level;
  logic        sub_level_d;
  logic [2:0]  alive_sync;
  logic        main_alive;
  logic [15:0] settle_cnt;
  logic        settling;
  logic        standby;
  logic        stop_mode;
  logic        wake;
  logic        processor_clock_control_status;

  clk_switch_if sw_if ();

  clk_switch u_switch (
    .clk    (CLK),
    .resetn (RESETN),
    .sw     (sw_if.sw)
  );

  // ---------------- APB decode ----------------
  logic [9:0] idx;
  logic       mapped;
  logic       access;
  logic       do_write;
  logic       do_read;
  logic       stall;
  reg8_t      wmask;
  reg8_t      wbyte;
  reg8_t      rbyte;

  assign idx    = PADDR[11:2];
  assign mapped = (idx == A_PSC) || (idx == A_PCC) || (idx == A_POWER_SAVE_MODE) ||
                  (idx == A_PROT) || (idx == A_OSC_SETTLE_SELECT);
  assign access = PSEL && PENABLE && PREADY;
  assign do_write = access && PWRITE && mapped;
  assign do_read  = access && !PWRITE && mapped;
  assign wbyte  = PWDATA[7:0];

  // byte lane 1 carries a bit mask for single-bit access
  always_comb begin
    if (PSTRB[1]) begin
      wmask = PWDATA[15:8];
    end else if (PSTRB[0]) begin
      wmask = 8'hFF;
    end else begin
      wmask = 8'h00;
    end
  end

  // the settle register needs the main clock for its wait
  assign stall = (idx == A_OSC_SETTLE_SELECT) && sw_if.on_sub && !main_alive;

  always_comb begin
    unique case (idx)
      A_PSC:   rbyte = power_save_control;
      A_PCC:   rbyte = processor_clock_control | {3'b000, processor_clock_control_status, 4'h0};
      A_POWER_SAVE_MODE:  rbyte = power_save_mode;
      A_OSC_SETTLE_SELECT:  rbyte = osc_settle_select;
      default: rbyte = 8'h00;
    endcase
  end

  // one wait state, held off while stall is set; answer registered
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY && !stall) begin
      PREADY  <= 1'b1;
      PRDATA  <= {24'h00_0000, rbyte};
      PSLVERR <= !mapped;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // key write arms exactly the next transfer
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      protect_armed <= 1'b0;
    end else if (access) begin
      protect_armed <= PWRITE && (idx == A_PROT) && (wbyte == `PROTECT_KEY);
    end
  end

  // ---------------- clock control ----------------
  reg8_t pcc_new;
  always_comb begin
    pcc_new = (processor_clock_control & ~wmask) | (wbyte & wmask);
    pcc_new[`PCC_CPU_ON_SUBCLOCK] = 1'b0;
    // prohibited 011x leaves the selector as it was
    if (!pcc_new[3] && (pcc_new[2:1] == 2'b11)) begin
      pcc_new[3:0] = processor_clock_control[3:0];
    end
  end

  // reset selects main clock divided by eight
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      processor_clock_control <= `PCC_RESET;
    end else begin
      if (do_write && (idx == A_PCC) && protect_armed) begin
        processor_clock_control <= pcc_new;
      end
    end
  end

  // ---------------- power save registers ----------------
  reg8_t psc_new;
  assign psc_new = ((power_save_control & ~wmask) | (wbyte & wmask)) & `PSC_WRITABLE;

  // request cleared by wake; software write wins
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      power_save_control <= `PSC_RESET;
    end else if (do_write && (idx == A_PSC) && protect_armed) begin
      power_save_control <= psc_new;
    end else if (wake) begin
      power_save_control[`PSC_STANDBY_REQUEST] <= 1'b0;
    end
  end

  // only the kind bit is stored
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      power_save_mode <= `POWER_SAVE_MODE_RESET;
    end else if (do_write && (idx == A_POWER_SAVE_MODE)) begin
      power_save_mode[`POWER_SAVE_MODE_STANDBY_KIND_SELECT] <=
        (power_save_mode[0] & ~wmask[0]) | (wbyte[0] & wmask[0]);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      osc_settle_select <= `OSC_SETTLE_SELECT_RESET;
    end else if (do_write && (idx == A_OSC_SETTLE_SELECT)) begin
      osc_settle_select <= {5'b0_0000, ((osc_settle_select[2:0] & ~wmask[2:0]) | (wbyte[2:0] & wmask[2:0]))};
    end
  end

  // ---------------- clock sources ----------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div_cnt <= 5'b0_0000;
    end else begin
      div_cnt <= div_cnt + 5'b0_0001;
    end
  end

  // divide by 1, 2, 4, 8, 16 or 32
  always_comb begin
    unique case (processor_clock_control[2:0])
      3'h0:    main_en = 1'b1;
      3'h1:    main_en = div_cnt[0];
      3'h2:    main_en = &div_cnt[1:0];
      3'h3:    main_en = &div_cnt[2:0];
      3'h4:    main_en = &div_cnt[3:0];
      3'h5:    main_en = &div_cnt[4:0];
      default: main_en = &div_cnt[4:0];
    endcase
  end

  // sub oscillator pin, accepted once stages two and three agree
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sub_sync    <= 3'b000;
      sub_level   <= 1'b0;
      sub_level_d <= 1'b0;
    end else begin
      sub_sync    <= {sub_sync[1:0], SUB_OSC_IN};
      sub_level_d <= sub_level;
      if (sub_sync[1] == sub_sync[2]) begin
        sub_level <= sub_sync[2];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      alive_sync <= 3'b000;
      main_alive <= 1'b0;
    end else begin
      alive_sync <= {alive_sync[1:0], MAIN_OSC_INPUT_ALIVE};
      if (alive_sync[1] == alive_sync[2]) begin
        main_alive <= alive_sync[2];
      end
    end
  end

  // switching handled by the switch module
  assign sw_if.want_sub = processor_clock_control[`PCC_CLK_SEL_TOP];
  assign sw_if.main_en  = main_en && !MAIN_OSC_STOP;
  assign sw_if.sub_tick = sub_level && !sub_level_d;

  // ---------------- standby ----------------
  // kind matters only while the request is set
  assign standby   = power_save_control[`PSC_STANDBY_REQUEST];
  assign stop_mode = standby && power_save_mode[`POWER_SAVE_MODE_STANDBY_KIND_SELECT];

  // masks gate only in STOP; IDLE wakes on any request
  always_comb begin
    if (stop_mode) begin
      wake = (WATCHDOG_NMI_REQUEST && !power_save_control[`PSC_WDT_NMI_MASK]) ||
             (PIN_NMI_REQUEST && !power_save_control[`PSC_PIN_NMI_MASK]) ||
             (MASKABLE_IRQ_REQUEST && !power_save_control[`PSC_MASKABLE_IRQ_MASK]);
    end else if (standby) begin
      wake = WATCHDOG_NMI_REQUEST || PIN_NMI_REQUEST || MASKABLE_IRQ_REQUEST;
    end else begin
      wake = 1'b0;
    end
  end

  // settle after reset and after leaving STOP
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      settle_cnt <= 16'h0000;
      settling   <= 1'b1;
    end else if (wake && stop_mode) begin
      settle_cnt <= 16'h0000;
      settling   <= 1'b1;
    end else if (settling) begin
      settle_cnt <= settle_cnt + 16'h0001;
      if (settle_cnt == 16'((32'd1 << (32'(osc_settle_select[2:0]) + SETTLE_SHIFT)) - 32'd1)) begin
        settling <= 1'b0;
      end
    end
  end

  // ---------------- outputs, all registered ----------------
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CPU_CLK_EN <= 1'b0;
      SYS_CLK_EN <= 1'b0;
    end else begin
      CPU_CLK_EN <= sw_if.cpu_en && !standby && !settling;
      SYS_CLK_EN <= sw_if.cpu_en && !standby && !settling;
    end
  end

  // stop honoured only on subclock, or in STOP
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      MAIN_OSC_STOP <= 1'b0;
    end else begin
      MAIN_OSC_STOP <= (stop_mode && !wake) ||
                       (processor_clock_control[`PCC_MAIN_OSC_STOP] && sw_if.on_sub);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      MAIN_FEEDBACK_OFF <= 1'b0;
      SUB_FEEDBACK_OFF  <= 1'b0;
    end else begin
      MAIN_FEEDBACK_OFF <= processor_clock_control[`PCC_MAIN_FEEDBACK_OFF];
      SUB_FEEDBACK_OFF  <= processor_clock_control[`PCC_SUB_FEEDBACK_OFF];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      IN_IDLE    <= 1'b0;
      IN_STOP    <= 1'b0;
      SETTLING   <= 1'b1;
      WAKE_EVENT <= 1'b0;
    end else begin
      IN_IDLE    <= standby && !stop_mode;
      IN_STOP    <= stop_mode;
      SETTLING   <= settling;
      WAKE_EVENT <= wake;
    end
  end

  // status bit mirrors the switch, never stored from writes
  always_comb begin
    processor_clock_control_status = sw_if.on_sub;
  end

endmodule : cpu_clock_and_standby_control

//--- sim/cpu_clock_and_standby_control_assertions.sv
`timescale 1ns/1ns
module clk_ctrl_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic              CLK,
  input wire logic              RESETN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [3:0]        PSTRB,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              WATCHDOG_NMI_REQUEST,
  input wire logic              PIN_NMI_REQUEST,
  input wire logic              MASKABLE_IRQ_REQUEST,
  input wire logic              CPU_CLK_EN,
  input wire logic              SYS_CLK_EN,
  input wire logic              MAIN_OSC_STOP,
  input wire logic              MAIN_FEEDBACK_OFF,
  input wire logic              SUB_FEEDBACK_OFF,
  input wire logic              IN_IDLE,
  input wire logic              IN_STOP,
  input wire logic              SETTLING,
  input wire logic              WAKE_EVENT
);
  logic       done;
  logic       pcc_wr;
  logic       armed;
  logic [1:0] fb_exp;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  assign done   = PSEL && PENABLE && PREADY;
  assign pcc_wr = done && PWRITE && PADDR == 12'h0A0 && PSTRB[1:0] == 2'b01;

  // any other completed transfer disarms the key
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      armed <= 1'b0;
    end else if (done) begin
      armed <= PWRITE && PADDR == 12'h3F0 && PWDATA[7:0] == 8'hA5;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      fb_exp <= 2'b00;
    end else if (pcc_wr && armed) begin
      fb_exp <= {PWDATA[7], PWDATA[5]};
    end
  end

  // the settle select index stalls on purpose when main clock is absent
  sequence setup_s;
    PSEL && !PENABLE && PADDR != 12'h0AC;
  endsequence

  sequence idle_wake_s;
    IN_IDLE && !WAKE_EVENT && (WATCHDOG_NMI_REQUEST || PIN_NMI_REQUEST || MASKABLE_IRQ_REQUEST);
  endsequence

  ready_wait_a: assert property (setup_s |-> ##2 PREADY)
    else $error("answer not after one wait state");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  err_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("error response malformed");
  reset_state_a: assert property (disable iff (1'b0) !RESETN |=> SETTLING && !CPU_CLK_EN && !PREADY)
    else $error("outputs not in reset state");
  settle_hold_a: assert property (SETTLING |-> !CPU_CLK_EN)
    else $error("cpu clock during settle");
  sys_follow_a: assert property (SYS_CLK_EN == CPU_CLK_EN)
    else $error("system enable differs from cpu enable");
  idle_gate_a: assert property (IN_IDLE && $past(IN_IDLE) |-> !CPU_CLK_EN)
    else $error("cpu clock during idle");
  idle_wake_a: assert property (idle_wake_s |=> WAKE_EVENT)
    else $error("request did not wake idle");
  stop_osc_a: assert property ($rose(IN_STOP) |-> ##[0:1] MAIN_OSC_STOP)
    else $error("main oscillator runs in stop");
  fb_follow_a: assert property (pcc_wr && armed |-> ##[1:2] {SUB_FEEDBACK_OFF, MAIN_FEEDBACK_OFF} == fb_exp)
    else $error("feedback outputs not following write");
  plain_drop_a: assert property (pcc_wr && !armed |=> ($stable(SUB_FEEDBACK_OFF) && $stable(MAIN_FEEDBACK_OFF)) [*2])
    else $error("unprotected write took effect");
endmodule : clk_ctrl_checker

bind cpu_clock_and_standby_control clk_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
  .CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR,
  .WATCHDOG_NMI_REQUEST, .PIN_NMI_REQUEST, .MASKABLE_IRQ_REQUEST, .CPU_CLK_EN, .SYS_CLK_EN, .MAIN_OSC_STOP,
  .MAIN_FEEDBACK_OFF, .SUB_FEEDBACK_OFF, .IN_IDLE, .IN_STOP, .SETTLING, .WAKE_EVENT
);

//--- sim/cpu_clock_and_standby_control_tb.sv
`timescale 1ns/1ns
module cpu_clock_and_standby_control_tb;
  localparam logic [11:0] a_pcc = 12'h0A0;
  localparam logic [11:0] a_psc = 12'h7F8;
  localparam logic [11:0] a_psm = 12'h0A8;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sub_osc;
  logic        main_alive;
  logic        wdt_req;
  logic        pin_req;
  logic        irq_req;
  logic        cpu_en;
  logic        osc_stop;
  logic        main_fb;
  logic        sub_fb;
  logic        in_idle;
  logic        in_stop;
  logic        settling;
  logic [31:0] rdat;
  logic        rerr;
  int          n;
  int          error_cnt;
  int          comparisons;

  cpu_clock_and_standby_control #(.SETTLE_SHIFT(1)) uut (
    .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SUB_OSC_IN(sub_osc), .MAIN_OSC_INPUT_ALIVE(main_alive), .WATCHDOG_NMI_REQUEST(wdt_req),
    .PIN_NMI_REQUEST(pin_req), .MASKABLE_IRQ_REQUEST(irq_req), .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(),
    .MAIN_OSC_STOP(osc_stop), .MAIN_FEEDBACK_OFF(main_fb), .SUB_FEEDBACK_OFF(sub_fb),
    .IN_IDLE(in_idle), .IN_STOP(in_stop), .SETTLING(settling), .WAKE_EVENT()
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // free-running subclock, 20 system cycles per period
  initial begin
    sub_osc = 1'b0;
    forever begin
      repeat (10) @(posedge clk);
      sub_osc <= ~sub_osc;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  // d holds mask in [15:8] and data in [7:0]
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic pw(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    xfer(1'b1, 12'h3F0, 16'h00A5, 4'h1);
    xfer(1'b1, a, d, s);
  endtask : pw

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 16'h0000, 4'h0);
    chk(rdat, e);
  endtask : rchk

  task automatic cnt;
    n = 0;
    repeat (64) begin
      @(posedge clk);
      n += int'(cpu_en);
    end
  endtask : cnt

  task automatic poll(input logic v);
    for (int k = 0; k < 30; k++) begin
      xfer(1'b0, a_pcc, 16'h0000, 4'h0);
      if (rdat[4] === v) break;
    end
    chk(rdat[4], v);
  endtask : poll

  task automatic t_reset;
    chk(settling, 1);
    rchk(a_pcc, 32'h0000_0003);
    rchk(a_psc, 32'h0000_0000);
    rchk(a_psm, 32'h0000_0000);
    xfer(1'b0, 12'h040, 16'h0000, 4'h0);
    chk(rdat, 32'h0000_0000);
    chk(rerr, 1);
    repeat (200) if (settling) @(posedge clk);
    chk(settling, 0);
  endtask : t_reset

  task automatic t_prot;
    xfer(1'b1, a_pcc, 16'h00A2, 4'h1);
    rchk(a_pcc, 32'h0000_0003);
    xfer(1'b1, 12'h3F0, 16'h00A5, 4'h1);
    xfer(1'b0, a_psc, 16'h0000, 4'h0);
    xfer(1'b1, a_psc, 16'h0090, 4'h1);
    rchk(a_psc, 32'h0000_0000);
    pw(a_psc, 16'h00FD, 4'h1);
    rchk(a_psc, 32'h0000_00B0);
    pw(a_psc, 16'h0000, 4'h1);
  endtask : t_prot

  task automatic t_bits;
    xfer(1'b1, a_psm, 16'h0101, 4'h2);
    rchk(a_psm, 32'h0000_0001);
    xfer(1'b1, a_psm, 16'h00FE, 4'h1);
    rchk(a_psm, 32'h0000_0000);
    pw(a_pcc, 16'h2020, 4'h2);
    rchk(a_pcc, 32'h0000_0023);
    chk(main_fb, 1);
    pw(a_pcc, 16'h8080, 4'h2);
    rchk(a_pcc, 32'h0000_00A3);
    chk(sub_fb, 1);
    pw(a_pcc, 16'h0013, 4'h1);
    rchk(a_pcc, 32'h0000_0003);
    chk({sub_fb, main_fb}, 0);
  endtask : t_bits

  task automatic t_div;
    cnt;
    chk(n, 8);
    for (int i = 0; i < 6; i++) begin
      pw(a_pcc, 16'(i), 4'h1);
      repeat (40) @(posedge clk);
      cnt;
      chk(n, 64 >> i);
    end
    pw(a_pcc, 16'h0006, 4'h1);
    rchk(a_pcc, 32'h0000_0005);
    pw(a_pcc, 16'h0003, 4'h1);
  endtask : t_div

  task automatic t_sub;
    pw(a_pcc, 16'h4040, 4'h2);
    repeat (20) @(posedge clk);
    chk(osc_stop, 0);
    pw(a_pcc, 16'h0808, 4'h2);
    poll(1'b1);
    rchk(a_pcc, 32'h0000_005B);
    chk(osc_stop, 1);
    pw(a_pcc, 16'h4000, 4'h2);
    repeat (4) @(posedge clk);
    chk(osc_stop, 0);
    pw(a_pcc, 16'h0800, 4'h2);
    poll(1'b0);
  endtask : t_sub

  task automatic t_standby;
    pw(a_psc, 16'h0002, 4'h1);
    @(posedge clk);
    cnt;
    chk({in_idle, n[7:0]}, 9'h100);
    wdt_req <= 1'b1;
    repeat (4) @(posedge clk);
    wdt_req <= 1'b0;
    rchk(a_psc, 32'h0000_0000);
    chk(in_idle, 0);
    xfer(1'b1, a_psm, 16'h0001, 4'h1);
    pw(a_psc, 16'h0012, 4'h1);
    irq_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk({in_stop, osc_stop}, 2'b11);
    irq_req <= 1'b0;
    pin_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk({in_stop, settling}, 2'b01);
    pin_req <= 1'b0;
    rchk(a_psc, 32'h0000_0010);
  endtask : t_standby

  // settle register access on subclock without main clock hangs until reset
  task automatic t_stall;
    pw(a_pcc, 16'h0808, 4'h2);
    poll(1'b1);
    main_alive <= 1'b0;
    repeat (8) @(posedge clk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= 12'h0AC;
    pstrb <= 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += int'(pready);
    end
    chk(n, 0);
    resetn <= 1'b0;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    main_alive <= 1'b1;
    repeat (7) @(posedge clk);
    resetn <= 1'b1;
    chk(settling, 1);
    rchk(a_pcc, 32'h0000_0003);
  endtask : t_stall

  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    {resetn, psel, penable, pwrite, wdt_req, pin_req, irq_req} = 7'h00;
    {paddr, pwdata, pstrb} = 48'h0;
    main_alive = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_prot;
    t_bits;
    t_div;
    t_sub;
    t_standby;
    t_stall;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test;
  end
endmodule : cpu_clock_and_standby_control_tb
